// >>> verif/bus_master_model.sv
// Behavioural model of the six bus matrix masters presenting addresses
`timescale 1ns/1ns
module bus_master_model
   import mem_decode_pkg::*;
(
   input wire logic sys_clk_i,
   output logic [NUM_MASTERS-1:0] req_o,
   output logic [NUM_MASTERS*ADDR_W-1:0] addr_o
);
   // -----------------------------------------------
   // Idle state: no request, address lines scrambled
   // -----------------------------------------------
   initial begin
      req_o = '0;
      addr_o = {NUM_MASTERS{32'h5A5A_A5A5}};
   end

   // One transfer: held for one sampling edge, then released
   task automatic access(input int m, input logic [31:0] a);
      @(negedge sys_clk_i);
      req_o[m] = 1'b1;
      addr_o[m*ADDR_W +: ADDR_W] = a;
      @(negedge sys_clk_i);
      req_o[m] = 1'b0;
      addr_o[m*ADDR_W +: ADDR_W] = ~a; // Released lines do not keep the value
   endtask
endmodule

// >>> verif/tb.sv
// Self-checking testbench for the memory decoder and remap block
`timescale 1ns/1ns
module tb;
   import mem_decode_pkg::*;
   localparam logic [4:0] RO = 5'h01, SR = 5'h02, EX = 5'h04, PE = 5'h08, AB = 5'h10;
   logic sys_clk = 1'b0, reset_n = 1'b0, boot = 1'b1, sen = 1'b0, swr = 1'b0;
   logic [5:0] remap = 6'h00, req, sel_rom, sel_sram, sel_ext, sel_periph, abort, remap_act;
   logic [1:0] isz = 2'h0, dsz = 2'h0, isz_o, dsz_o;
   logic [191:0] addr;
   logic [31:0] saddr = 32'h0, swd = 32'h0, srd;
   logic [17:0] ext_bank;
   logic [11:0] blk;
   logic [89:0] rom_a;
   logic boot_rom, srdy, serr;
   int bad_count = 0, num_checks = 0;

   always #25 sys_clk = ~sys_clk;

   bus_master_model mst_u (.sys_clk_i(sys_clk), .req_o(req), .addr_o(addr));

   mem_decode_remap dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
      .boot_select_level_i(boot), .per_master_remap_bit_i(remap), .instr_size_i(isz),
      .data_size_i(dsz), .req_i(req), .addr_i(addr), .sram_en_i(sen), .sram_wr_i(swr),
      .sram_addr_i(saddr), .sram_wdata_i(swd), .sel_rom_o(sel_rom), .sel_sram_o(sel_sram),
      .sel_ext_o(sel_ext), .sel_periph_o(sel_periph), .abort_o(abort),
      .ext_bank_o(ext_bank), .sram_block_o(blk), .rom_addr_o(rom_a), .remap_active_o(remap_act),
      .boot_from_rom_o(boot_rom), .instr_size_o(isz_o), .data_size_o(dsz_o),
      .sram_rdata_o(srd), .sram_ready_o(srdy), .sram_error_o(serr));

   // -----------------------------------------------
   // Comparison, verdict and reset helpers
   // -----------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Reset with a given boot level, level captured at the first edge after release
   task automatic do_reset(input logic lvl);
      @(negedge sys_clk);
      reset_n = 1'b0;
      boot = lvl;
      repeat (3) @(negedge sys_clk);
      reset_n = 1'b1;
      @(negedge sys_clk);
   endtask

   // One decode: route one-hot and, where relevant, block or external bank
   task automatic probe(input int m, input logic [31:0] a, input logic [4:0] e,
                        input logic [2:0] b);
      mst_u.access(m, a);
      check("route", {abort[m], sel_periph[m], sel_ext[m], sel_sram[m], sel_rom[m]}, e);
      if (e == SR) check("block", blk[m*2 +: 2], b[1:0]);
      if (e == EX) check("ext_bank", ext_bank[m*3 +: 3], b);
      if (e == RO) check("rom_addr", rom_a[m*15 +: 15], a[14:0]);
   endtask

   // Sizes change only with no request outstanding
   task automatic set_sizes(input logic [1:0] i, input logic [1:0] d);
      @(negedge sys_clk);
      isz = i;
      dsz = d;
      repeat (2) @(negedge sys_clk);
   endtask

   // -----------------------------------------------
   // Scenarios
   // -----------------------------------------------
   task automatic t_reset();
      check("remap_act", remap_act, 6'h00);
      check("sizes", {isz_o, dsz_o}, 4'h0);
      boot = 1'b0;
      repeat (2) @(negedge sys_clk);
      check("boot_held", boot_rom, 1'b1);
      $display("t_reset done");
   endtask

   task automatic t_banks();
      logic [31:0] at [10] = '{32'h1000_0000, 32'h8FFF_FFFC, 32'hF000_0000, 32'h9000_0000,
         32'hE000_0000, 32'h0040_0000, 32'h0050_0000, 32'h0030_C000, 32'h0000_0000,
         32'h0010_0000};
      logic [4:0] et [10] = '{EX, EX, PE, AB, AB, RO, AB, SR, RO, AB};
      logic [2:0] bt [10] = '{3'h0, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
      for (int i = 0; i < 10; i++) begin
         probe(i % 6, at[i], et[i], bt[i]);
      end
      probe(0, 32'hF000_0000, PE, 3'h0);
      probe(0, 32'hA000_0000, AB, 3'h0);
      probe(1, 32'h3000_0000, EX, 3'h2);
      probe(2, 32'h0040_0000, RO, 3'h0);
      probe(5, 32'h0040_7FFC, RO, 3'h0);
      probe(4, 32'h0040_8000, AB, 3'h0);
      $display("t_banks done");
   endtask

   task automatic t_remap();
      @(negedge sys_clk);
      remap = 6'h3F;
      repeat (2) @(negedge sys_clk);
      check("remap_act", remap_act, 6'h3F);
      probe(MASTER_INSTR, 32'h0000_0000, SR, 3'h3);
      probe(MASTER_DATA, 32'h0000_4000, SR, 3'h2);
      probe(MASTER_DATA, 32'h0000_0000, SR, 3'h3);
      probe(0, 32'h0000_0000, AB, 3'h0);
      probe(1, 32'h0030_0000, SR, 3'h3);
      remap = 6'h00;
      repeat (2) @(negedge sys_clk);
      probe(MASTER_INSTR, 32'h0000_0000, RO, 3'h0);
      $display("t_remap done");
   endtask

   task automatic t_carve();
      set_sizes(SIZE_32K, SIZE_32K);
      check("isz", isz_o, SIZE_32K);
      probe(0, 32'h0010_0000, SR, 3'h1);
      probe(2, 32'h0010_4000, SR, 3'h0);
      probe(3, 32'h0020_0000, SR, 3'h3);
      probe(5, 32'h0020_4000, SR, 3'h2);
      probe(1, 32'h0030_0000, AB, 3'h0);
      set_sizes(SIZE_16K, SIZE_16K);
      probe(0, 32'h0030_0000, SR, 3'h2);
      probe(4, 32'h0030_4000, SR, 3'h0);
      probe(1, 32'h0030_8000, AB, 3'h0);
      set_sizes(2'h3, SIZE_0K);
      probe(2, 32'h0030_C000, SR, 3'h0);
      set_sizes(SIZE_0K, SIZE_0K);
      $display("t_carve done");
   endtask

   task automatic sram_op(input logic wr, input logic [31:0] a, input logic [31:0] d,
                          input logic err);
      @(negedge sys_clk);
      sen = 1'b1;
      swr = wr;
      saddr = a;
      swd = d;
      @(negedge sys_clk);
      sen = 1'b0;
      swd = ~d;
      check("sram_ready", {srdy, serr}, {~err, err});
   endtask

   task automatic t_sram();
      sram_op(1'b1, 32'h0030_0004, 32'hC3A5_1E0F, 1'b0);
      sram_op(1'b1, 32'h0030_C008, 32'h0F1E_A5C3, 1'b0);
      sram_op(1'b0, 32'h0030_0004, 32'h0, 1'b0);
      check("rdata", srd, 32'hC3A5_1E0F);
      sram_op(1'b0, 32'h0030_C008, 32'h0, 1'b0);
      check("rdata", srd, 32'h0F1E_A5C3);
      sram_op(1'b0, 32'h0050_0000, 32'h0, 1'b1);
      $display("t_sram done");
   endtask

   task automatic t_boot_low();
      do_reset(1'b0);
      check("boot_rom", boot_rom, 1'b0);
      boot = 1'b1;
      probe(0, 32'h0000_0000, EX, 3'h0);
      probe(3, 32'h0040_0000, RO, 3'h0);
      $display("t_boot_low done");
   endtask

   initial begin
      do_reset(1'b1);
      t_reset();
      t_banks();
      t_remap();
      t_carve();
      t_sram();
      t_boot_low();
      conclude();
   end

   // Watchdog: the whole run needs well under 400 cycles
   initial begin
      #100000;
      bad_count++;
      conclude();
   end
endmodule

// >>> verilog/mem_decode_pkg.sv
// Constants for the internal memory decoder and remap block
package mem_decode_pkg;
   localparam int ADDR_W = 32;
   localparam int BANK_W = 4;
   localparam int NUM_MASTERS = 6;
   localparam int MASTER_INSTR = 4;
   localparam int MASTER_DATA = 5;
   // Bank numbers
   localparam logic [3:0] BANK_INTERNAL = 4'h0;
   localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
   localparam logic [3:0] BANK_EXT_LAST = 4'h8;
   localparam logic [3:0] BANK_PERIPH = 4'hF;
   // Internal region: bits 27:20 of bank zero
   localparam logic [7:0] REGION_BOOT = 8'h00;
   localparam logic [7:0] REGION_INSTR = 8'h01;
   localparam logic [7:0] REGION_DATA = 8'h02;
   localparam logic [7:0] REGION_GENERAL = 8'h03;
   localparam logic [7:0] REGION_ROM = 8'h04;
   localparam int REGION_LSB = 20;
   localparam int SLOT_LSB = 14;
   localparam int SLOT_W = 6;
   localparam int ROM_ADDR_W = 15;
   localparam logic [19:0] ROM_SIZE_BYTES = 20'h08000;
   localparam int SRAM_BLOCKS = 4;
   localparam int SRAM_WORD_ADDR_W = 14;
   localparam int BLOCK_WORD_W = 12;
   // Coupled area size codes: 0, 16 or 32 Kbytes
   localparam logic [1:0] SIZE_0K = 2'h0;
   localparam logic [1:0] SIZE_16K = 2'h1;
   localparam logic [1:0] SIZE_32K = 2'h2;
   localparam logic [1:0] RESET_SIZE = SIZE_0K;
   // Target slave selection
   typedef enum {
      TGT_NONE, TGT_ROM, TGT_SRAM, TGT_EXT, TGT_PERIPH
   } target_e;
endpackage

// >>> verilog/mem_decode_remap.sv
// Bus matrix address decoder with remap, boot select and SRAM carving
`timescale 1ns/1ns
module mem_decode_remap
   import mem_decode_pkg::*;
#(
   parameter int MASTERS = NUM_MASTERS
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic boot_select_level_i,
   input wire logic [MASTERS-1:0] per_master_remap_bit_i,
   input wire logic [1:0] instr_size_i,
   input wire logic [1:0] data_size_i,
   input wire logic [MASTERS-1:0] req_i,
   input wire logic [MASTERS*ADDR_W-1:0] addr_i,
   input wire logic sram_en_i,
   input wire logic sram_wr_i,
   input wire logic [ADDR_W-1:0] sram_addr_i,
   input wire logic [31:0] sram_wdata_i,
   output logic [MASTERS-1:0] sel_rom_o,
   output logic [MASTERS-1:0] sel_sram_o,
   output logic [MASTERS-1:0] sel_ext_o,
   output logic [MASTERS-1:0] sel_periph_o,
   output logic [MASTERS-1:0] abort_o,
   output logic [MASTERS*3-1:0] ext_bank_o,
   output logic [MASTERS*2-1:0] sram_block_o,
   output logic [MASTERS*ROM_ADDR_W-1:0] rom_addr_o,
   output logic [MASTERS-1:0] remap_active_o,
   output logic boot_from_rom_o,
   output logic [1:0] instr_size_o,
   output logic [1:0] data_size_o,
   output logic [31:0] sram_rdata_o,
   output logic sram_ready_o,
   output logic sram_error_o
);
   // ------------------------------------------------------------
   // Boot select capture and configuration
   // ------------------------------------------------------------
   logic boot_captured;
   logic next_boot_captured;
   logic boot_taken;
   logic next_boot_taken;
   logic [MASTERS-1:0] remap;
   logic [MASTERS-1:0] next_remap;
   logic [1:0] isize;
   logic [1:0] next_isize;
   logic [1:0] dsize;
   logic [1:0] next_dsize;
   logic any_req;

   assign any_req = |req_i;

   // First clock after reset release latches the boot level once
   always_comb begin
      next_boot_taken = 1'b1;
      next_boot_captured = boot_taken ? boot_captured : boot_select_level_i;
      next_remap = remap;
      next_isize = isize;
      next_dsize = dsize;
      for (int m = 0; m < MASTERS; m++) begin
         if (!req_i[m]) begin
            next_remap[m] = per_master_remap_bit_i[m];
         end
      end
      if (!any_req) begin
         next_isize = (instr_size_i == SIZE_32K) ? SIZE_32K :
                      (instr_size_i == SIZE_16K) ? SIZE_16K : SIZE_0K;
         next_dsize = (data_size_i == SIZE_32K) ? SIZE_32K :
                      (data_size_i == SIZE_16K) ? SIZE_16K : SIZE_0K;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         boot_taken <= 1'b0;
         boot_captured <= 1'b1;
         remap <= '0;
         isize <= RESET_SIZE;
         dsize <= RESET_SIZE;
      end else begin
         boot_taken <= next_boot_taken;
         boot_captured <= next_boot_captured;
         remap <= next_remap;
         isize <= next_isize;
         dsize <= next_dsize;
      end
   end

   // ------------------------------------------------------------
   // Block lookup: area and slot give a physical block
   // ------------------------------------------------------------
   function automatic logic [2:0] block_of(input logic [7:0] region,
                                           input logic [SLOT_W-1:0] slot,
                                           input logic [1:0] isz,
                                           input logic [1:0] dsz);
      logic [2:0] res;
      logic [2:0] gen_cnt;
      logic [2:0] idx;
      res = 3'h4;
      gen_cnt = 3'h4 - {1'b0, isz} - {1'b0, dsz};
      idx = 3'h0;
      if (region == REGION_INSTR && slot < {4'h0, isz}) begin
         res = (slot == '0) ? 3'h1 : 3'h0;
      end else if (region == REGION_DATA && slot < {4'h0, dsz}) begin
         res = (slot == '0) ? 3'h3 : 3'h2;
      end else if (region == REGION_GENERAL && slot < {3'h0, gen_cnt}) begin
         // Leftover blocks, highest first
         for (int b = 3; b >= 0; b--) begin
            if (!((b < 2 && {1'b0, b[1:0]} >= 3'h2 - {1'b0, isz}) ||
                  (b >= 2 && {1'b0, b[1:0]} >= 3'h4 - {1'b0, dsz}))) begin
               if (slot[2:0] == idx) begin
                  res = {1'b0, b[1:0]};
               end
               idx = idx + 3'h1;
            end
         end
      end
      return res;
   endfunction

   // ------------------------------------------------------------
   // Per-master decoders, identical except that only MASTER_INSTR and MASTER_DATA take the remap alias
   // ------------------------------------------------------------
   generate
      for (genvar m = 0; m < MASTERS; m++) begin : g_dec
         logic [ADDR_W-1:0] a;
         logic [3:0] bank;
         logic [7:0] region;
         logic [SLOT_W-1:0] slot;
         logic cpu_master;
         logic [7:0] eff_region;
         logic [2:0] blk;
         target_e tgt;
         logic [2:0] ext_bank;
         logic next_rom, next_sram, next_ext, next_per, next_abort;
         logic rom_q, sram_q, ext_q, per_q, abort_q;
         logic [2:0] ext_q_bank;
         logic [1:0] blk_q;
         logic [ROM_ADDR_W-1:0] rom_q_addr;

         assign a = addr_i[m*ADDR_W +: ADDR_W];
         assign bank = a[ADDR_W-1 -: BANK_W];
         assign region = a[27:REGION_LSB];
         assign slot = a[REGION_LSB-1:SLOT_LSB];
         assign cpu_master = (m == MASTER_INSTR) || (m == MASTER_DATA);

         // Route address zero through remap and boot choice
         always_comb begin
            eff_region = region;
            tgt = TGT_NONE;
            ext_bank = 3'h0;
            if (bank == BANK_INTERNAL && region == REGION_BOOT) begin
               if (remap[m] && cpu_master) begin
                  eff_region = REGION_GENERAL;
               end else if (!remap[m] && boot_captured) begin
                  eff_region = REGION_ROM;
               end else if (!remap[m]) begin
                  tgt = TGT_EXT;
               end
            end
            blk = block_of(eff_region, slot, isize, dsize);
            if (bank == BANK_INTERNAL && tgt == TGT_NONE) begin
               if (eff_region == REGION_ROM && a[19:0] < ROM_SIZE_BYTES) begin
                  tgt = TGT_ROM;
               end else if (!blk[2]) begin
                  tgt = TGT_SRAM;
               end
            end else if (bank >= BANK_EXT_FIRST && bank <= BANK_EXT_LAST) begin
               tgt = TGT_EXT;
               ext_bank = 3'(bank - BANK_EXT_FIRST);
            end else if (bank == BANK_PERIPH) begin
               tgt = TGT_PERIPH;
            end
            next_rom = req_i[m] && tgt == TGT_ROM;
            next_sram = req_i[m] && tgt == TGT_SRAM;
            next_ext = req_i[m] && tgt == TGT_EXT;
            next_per = req_i[m] && tgt == TGT_PERIPH;
            next_abort = req_i[m] && tgt == TGT_NONE;
         end

         always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               rom_q <= 1'b0;
               sram_q <= 1'b0;
               ext_q <= 1'b0;
               per_q <= 1'b0;
               abort_q <= 1'b0;
               ext_q_bank <= 3'h0;
               blk_q <= 2'h0;
               rom_q_addr <= '0;
            end else begin
               rom_q <= next_rom;
               sram_q <= next_sram;
               ext_q <= next_ext;
               per_q <= next_per;
               abort_q <= next_abort;
               ext_q_bank <= ext_bank;
               blk_q <= blk[1:0];
               rom_q_addr <= a[ROM_ADDR_W-1:0];
            end
         end

         assign sel_rom_o[m] = rom_q;
         assign sel_sram_o[m] = sram_q;
         assign sel_ext_o[m] = ext_q;
         assign sel_periph_o[m] = per_q;
         assign abort_o[m] = abort_q;
         assign ext_bank_o[m*3 +: 3] = ext_q_bank;
         assign sram_block_o[m*2 +: 2] = blk_q;
         assign rom_addr_o[m*ROM_ADDR_W +: ROM_ADDR_W] = rom_q_addr;
      end
   endgenerate

   assign remap_active_o = remap;
   assign boot_from_rom_o = boot_captured;
   assign instr_size_o = isize;
   assign data_size_o = dsize;

   // ------------------------------------------------------------
   // Bus-side SRAM port, one-cycle access
   // ------------------------------------------------------------
   logic [2:0] port_blk;
   logic port_hit;
   logic next_ready;
   logic next_error;

   always_comb begin
      port_blk = block_of(sram_addr_i[27:REGION_LSB], sram_addr_i[REGION_LSB-1:SLOT_LSB],
                          isize, dsize);
      port_hit = sram_en_i && !port_blk[2] && sram_addr_i[31:28] == BANK_INTERNAL;
      next_ready = port_hit;
      next_error = sram_en_i && !port_hit;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sram_ready_o <= 1'b0;
         sram_error_o <= 1'b0;
      end else begin
         sram_ready_o <= next_ready;
         sram_error_o <= next_error;
      end
   end

   sram_block_store #(
      .WORDS_PER_BLOCK(4096)
   ) u_store (
      .sys_clk_i(sys_clk_i),
      .en_i(port_hit),
      .wr_i(sram_wr_i),
      .block_i(port_blk[1:0]),
      .word_i(sram_addr_i[SLOT_LSB-1:2]),
      .wdata_i(sram_wdata_i),
      .rdata_o(sram_rdata_o)
   );

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   periph_route_a: assert property (
      req_i[0] && addr_i[31:28] == 4'hF |=> sel_periph_o[0])
      else $error("bank fifteen not routed to peripherals");
   ext_route_a: assert property (
      req_i[1] && addr_i[63:60] == 4'h3 |=> sel_ext_o[1] && ext_bank_o[5:3] == 3'h2)
      else $error("external bank routing wrong");
   unused_abort_a: assert property (
      req_i[0] && addr_i[31:28] == 4'hA |=> abort_o[0] && !sel_ext_o[0])
      else $error("unused bank did not abort");
   rom_fixed_a: assert property (
      req_i[2] && addr_i[95:64] == 32'h0040_0000 |=> sel_rom_o[2])
      else $error("fixed rom base not decoded");
   boot_hold_a: assert property (
      $past(boot_taken) |-> $stable(boot_from_rom_o))
      else $error("boot level changed after capture");
   dma_no_alias_a: assert property (
      req_i[0] && remap[0] && addr_i[31:0] == 32'h0 |=> !sel_sram_o[0])
      else $error("non-processor master saw sram alias");
   cpu_alias_a: assert property (
      req_i[5] && remap[5] && addr_i[191:160] == 32'h0 |=> sel_sram_o[5])
      else $error("processor data master missed sram alias");
   size_hold_a: assert property (
      any_req |=> $stable(instr_size_o) && $stable(data_size_o))
      else $error("sizes changed during a transfer");
   sram_one_cycle_a: assert property (
      port_hit |=> sram_ready_o ##1 !sram_ready_o || $past(port_hit))
      else $error("sram ready timing wrong");
   general_base_a: assert property (
      isize == SIZE_0K && dsize == SIZE_0K && sram_en_i
      && sram_addr_i[31:14] == 18'h000C0 |-> port_blk == 3'h3 ##1 sram_ready_o && !sram_error_o)
      else $error("general base not mapped");

   cover_remap_c: cover property (req_i[4] && remap[4] && addr_i[159:128] == 32'h0);
   cover_ext_boot_c: cover property (req_i[0] && !boot_captured && addr_i[31:0] == 32'h0);
   cover_sizes_c: cover property (isize == SIZE_32K && dsize == SIZE_32K);
endmodule

// >>> verilog/sram_block_store.sv
// Four-block internal SRAM with registered read data
`timescale 1ns/1ns
module sram_block_store
   import mem_decode_pkg::*;
#(
   parameter int WORDS_PER_BLOCK = 4096
) (
   input wire logic sys_clk_i,
   input wire logic en_i,
   input wire logic wr_i,
   input wire logic [1:0] block_i,
   input wire logic [BLOCK_WORD_W-1:0] word_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [0:SRAM_BLOCKS*WORDS_PER_BLOCK-1];
   logic [SRAM_WORD_ADDR_W-1:0] index;

   assign index = {block_i, word_i};

   // Single-cycle access: write or read, data out of a register
   always_ff @(posedge sys_clk_i) begin
      if (en_i && wr_i) begin
         mem[index] <= wdata_i;
      end
      if (en_i && !wr_i) begin
         rdata_o <= mem[index];
      end
   end
endmodule
